//--- watchdog_timeout_reset_tb.sv
// Self-checking bench for the watchdog: AHB-Lite master tasks, core model, random loads.
// Assumes one clock at 250 MHz and a synchronous active-high reset.
`timescale 1ns/1ps
module watchdog_timeout_reset_tb;
  logic        clk;
  logic        tb_rst;
  logic        sys_rst;
  wire         rst = tb_rst | sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        halt_req;
  logic        halt;
  logic        irq;
  logic        wdog;
  logic [31:0] q;
  logic [31:0] ld;
  logic [31:0] v1;
  int          failures;
  int          num_checks;
  int          cyc;

  wdr_watchdog dut (.sys_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .debug_halt_in(halt), .irq_out(irq), .wdog_reset_out(wdog));
  wdr_core_model core (.sys_clk_in(clk), .halt_req_in(halt_req), .wdog_reset_in(wdog),
    .debug_halt_out(halt), .sys_reset_out(sys_rst));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // One single transfer; address held until hready, data held until hready again
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h00000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    chk(hresp, 32'h0);
  endtask

  task automatic settle;
    @(posedge clk);
    #1;
  endtask

  task automatic do_rst;
    tb_rst <= 1'b1;
    repeat (4) @(posedge clk);
    tb_rst <= 1'b0;
  endtask

  // Longest gap from a reload to its time-out: load+1 cycles plus margin
  function automatic int lim(input logic [31:0] l);
    return int'(l) + 8;
  endfunction

  task automatic wt(input int n, input bit rs);
    for (int i = 0; i < n && (rs ? wdog : irq) !== 1'b1; i++) @(posedge clk);
    #1;
  endtask

  initial begin
    {tb_rst, hsel, htrans, hwrite, haddr, hwdata, halt_req} = '0;
    failures = 0;
    num_checks = 0;
    cyc = 0;
    void'($urandom(95));
    do_rst();
    bus(0, wdr_pkg::OFS_LOAD, 0);   chk(q, wdr_pkg::LOAD_RESET);
    bus(0, wdr_pkg::OFS_VALUE, 0);  chk(q, wdr_pkg::LOAD_RESET);
    bus(0, wdr_pkg::OFS_CTL, 0);    chk(q, 32'h0);
    bus(0, 12'hFD0, 0);             chk(q, 32'h0);
    ld = 32'd20 + ($urandom % 32);
    bus(1, wdr_pkg::OFS_LOAD, ld);
    bus(1, wdr_pkg::OFS_CTL, 32'h1);
    repeat (2 * lim(ld)) begin
      @(posedge clk);
      chk(wdog, 1'b0);
    end
    chk(irq, 1'b1);
    bus(0, wdr_pkg::OFS_RIS, 0);    chk(q, 32'h1);
    bus(0, wdr_pkg::OFS_MIS, 0);    chk(q, 32'h1);
    // Reload first so no time-out can land on the clear's own edge
    bus(1, wdr_pkg::OFS_LOAD, ld);
    settle();                       chk(irq, 1'b1);
    bus(1, wdr_pkg::OFS_ICR, $urandom);
    settle();                       chk(irq, 1'b0);
    bus(1, wdr_pkg::OFS_LOAD, 32'h0);
    settle();                       chk(irq, 1'b1);
    do_rst();
    ld = 32'd200 + ($urandom % 50);
    bus(1, wdr_pkg::OFS_LOAD, ld);
    bus(0, wdr_pkg::OFS_LOAD, 0);   chk(q, ld);
    bus(0, wdr_pkg::OFS_VALUE, 0);  chk(q, ld);
    bus(1, wdr_pkg::OFS_CTL, 32'h3);
    bus(1, wdr_pkg::OFS_CTL, 32'h0);
    bus(0, wdr_pkg::OFS_CTL, 0);    chk(q, 32'h3);
    bus(0, wdr_pkg::OFS_VALUE, 0);  chk(q <= ld && q > ld - 32'd24, 1);
    bus(1, wdr_pkg::OFS_TEST, 32'h100);
    halt_req <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, wdr_pkg::OFS_VALUE, 0);
    v1 = q;
    repeat (5) @(posedge clk);
    bus(0, wdr_pkg::OFS_VALUE, 0);  chk(q, v1);
    halt_req <= 1'b0;
    repeat (4) @(posedge clk);
    bus(0, wdr_pkg::OFS_VALUE, 0);  chk(q < v1 && q > v1 - 32'd16, 1);
    bus(1, wdr_pkg::OFS_LOCK, $urandom);
    bus(0, wdr_pkg::OFS_LOCK, 0);   chk(q, 32'h1);
    bus(1, wdr_pkg::OFS_LOAD, 32'h5);
    bus(0, wdr_pkg::OFS_LOAD, 0);   chk(q, ld);
    bus(1, wdr_pkg::OFS_CTL, 32'h0);
    bus(0, wdr_pkg::OFS_CTL, 0);    chk(q, 32'h3);
    bus(1, wdr_pkg::OFS_ICR, 32'h0);
    bus(0, wdr_pkg::OFS_VALUE, 0);  chk(q < ld - 32'd30, 1);
    bus(1, wdr_pkg::OFS_LOCK, wdr_pkg::UNLOCK_KEY);
    bus(0, wdr_pkg::OFS_LOCK, 0);   chk(q, 32'h0);
    bus(0, wdr_pkg::OFS_CLKGATE, 0); chk(q, 32'h1);
    bus(1, wdr_pkg::OFS_CLKGATE, 32'h0);
    bus(0, wdr_pkg::OFS_VALUE, 0);
    v1 = q;
    bus(0, wdr_pkg::OFS_VALUE, 0);  chk(q, v1);
    bus(1, wdr_pkg::OFS_CLKGATE, 32'h1);
    wt(lim(ld), 0);                 chk(irq, 1'b1);
    bus(0, wdr_pkg::OFS_VALUE, 0);  chk(q > ld - 32'd24, 1);
    bus(1, wdr_pkg::OFS_LOAD, ld);
    settle();                       chk(irq, 1'b1);
    bus(1, wdr_pkg::OFS_ICR, 32'h0);
    settle();                       chk(irq, 1'b0);
    wt(lim(ld), 0);                 chk(wdog, 1'b0);
    wt(lim(ld), 1);                 chk(wdog, 1'b1);
    repeat (4) @(posedge clk);
    chk(wdog, 1'b1);
    repeat (20) @(posedge clk);
    #1;
    chk(wdog, 1'b0);
    bus(0, wdr_pkg::OFS_CTL, 0);    chk(q, 32'h0);
    end_sim();
  end
endmodule

//--- wdr_core_model.sv
// Processor core model: drives the debug halt level and answers the watchdog reset.
// Assumes the bench commands halts; the system reset follows the request after a delay.
`timescale 1ns/1ps
module wdr_core_model (
  input  wire logic sys_clk_in,
  input  wire logic halt_req_in,
  input  wire logic wdog_reset_in,
  output logic      debug_halt_out,
  output logic      sys_reset_out
);
  logic [3:0] delay;
  initial begin
    debug_halt_out = 1'b0;
    sys_reset_out = 1'b0;
    delay = 4'h0;
  end
  // A real core needs some cycles to act, so the request must stay up meanwhile
  always @(posedge sys_clk_in) begin
    debug_halt_out <= halt_req_in;
    delay <= wdog_reset_in ? delay + 4'h1 : 4'h0;
    sys_reset_out <= wdog_reset_in && (delay >= 4'h8);
  end
endmodule

//--- wdr_pkg.sv
// Package for the watchdog timeout/reset block: register map, fields, reset values, state.
// Assumes a 32-bit AHB-Lite register bus with word-aligned single transfers.
package wdr_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_LOAD    = 12'h000;
  localparam logic [11:0] OFS_VALUE   = 12'h004;
  localparam logic [11:0] OFS_CTL     = 12'h008;
  localparam logic [11:0] OFS_ICR     = 12'h00C;
  localparam logic [11:0] OFS_RIS     = 12'h010;
  localparam logic [11:0] OFS_MIS     = 12'h014;
  localparam logic [11:0] OFS_CLKGATE = 12'h01C;
  localparam logic [11:0] OFS_TEST    = 12'h418;
  localparam logic [11:0] OFS_LOCK    = 12'hC00;

  // Field positions
  localparam int          BIT_TIMEOUT_IRQ_ENABLE  = 0;
  localparam int          BIT_SYSTEM_RESET_ENABLE  = 1;
  localparam int          BIT_STALL  = 8;
  localparam int          BIT_CLKEN  = 0;
  localparam int          BIT_STATUS = 0;

  // Values
  localparam logic [31:0] UNLOCK_KEY  = 32'h1ACCE551;
  localparam logic [31:0] LOAD_RESET  = 32'hFFFFFFFF;
  localparam logic [31:0] COUNT_ZERO  = 32'h00000000;
  localparam logic [31:0] WORD_ZERO   = 32'h00000000;
  localparam logic [31:0] COUNT_STEP  = 32'h00000001;
  localparam logic        CLKEN_RESET = 1'b1;

  // Bus data-phase tracker, one-hot
  typedef enum logic [3:0] {
    WDR_PH_IDLE  = 4'b0001,
    WDR_PH_WRITE = 4'b0010,
    WDR_PH_RWAIT = 4'b0100,
    WDR_PH_RDONE = 4'b1000
  } wdr_phase_t;

  typedef struct packed {
    logic [31:0] load;
    logic [31:0] count;
    logic        timeout_irq_enable;
    logic        system_reset_enable;
    logic        ris;
    logic        locked;
    logic        stall_en;
    logic        clk_gate;
    logic        rst_req;
    wdr_phase_t  phase;
    logic [11:0] dph_addr;
    logic [31:0] rdata;
  } wdr_state_t;

  localparam wdr_state_t STATE_RESET = '{
    load:     LOAD_RESET,
    count:    LOAD_RESET,
    timeout_irq_enable:    1'b0,
    system_reset_enable:    1'b0,
    ris:      1'b0,
    locked:   1'b0,
    stall_en: 1'b0,
    clk_gate: CLKEN_RESET,
    rst_req:  1'b0,
    phase:    WDR_PH_IDLE,
    dph_addr: 12'h000,
    rdata:    WORD_ZERO
  };

endpackage

//--- wdr_watchdog.sv
// Watchdog timer: 32-bit down counter, first time-out interrupt, second time-out reset.
// Assumes a single AHB-Lite master, synchronous active-high reset, and a debug halt level.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

// Functional notes
// - A 32-bit down counter starts from the software-written interval reload value.
// - Once enabled, the counter reaching zero signals the first time-out.
// - Setting the interrupt enable also starts the counter; no separate run bit.
// - After a time-out the counter reloads from the interval value and continues.
// - Zero again with interrupt pending and reset enabled asserts the system reset.
// - Clearing the interrupt before the second zero reloads and avoids the reset.
// - Writing the interval value while running loads the counter at once.
// - Writing the interval value leaves a pending interrupt asserted.
// - Enabling the interrupt preloads the counter from the interval value.
// - Software locks after configuring; while locked, configuration writes are refused.
// - With stalling enabled, counting stops while the debug halt input is high.
// - Counting runs only while the separate watchdog clock gate is enabled.
// - Raw status is readable apart from the masked interrupt output.
// - Interrupt and reset generation are enables; no reset output while reset disabled.
// - Writing zero as interval value raises the interrupt immediately.
// - Once interrupt enable is set, control writes are ignored until hardware reset.
// - Any unlocked write to the clear register reloads the counter and clears the interrupt, unless a time-out lands in that cycle.
// - Any lock-register write other than the unlock key locks; writing the unlock key unlocks.
module wdr_watchdog (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  input  wire logic        debug_halt_in,
  output logic             irq_out,
  output logic             wdog_reset_out
);

  wdr_pkg::wdr_state_t cur;
  wdr_pkg::wdr_state_t next_cur;

  logic        accept;
  logic        wr;
  logic        wr_load;
  logic        wr_ctl;
  logic        wr_icr;
  logic        run_ok;
  logic        timeout;
  logic [31:0] rd_mux;

  // Only single whole-word transfers are issued, so hsize is not decoded
  assign accept = hsel_in && htrans_in[1] && hready_in;
  assign wr     = (cur.phase == wdr_pkg::WDR_PH_WRITE);
  // Lock covers every configuration register, the clear register included
  assign wr_load = wr && !cur.locked && (cur.dph_addr == wdr_pkg::OFS_LOAD);
  assign wr_ctl  = wr && !cur.locked && (cur.dph_addr == wdr_pkg::OFS_CTL);
  // The clear register is the only path that drops the pending flag
  assign wr_icr  = wr && !cur.locked && (cur.dph_addr == wdr_pkg::OFS_ICR);

  // Interrupt enable doubles as run control, gated by clock gate and debug stall
  assign run_ok = cur.timeout_irq_enable && cur.clk_gate
                  && !(cur.stall_en && debug_halt_in);
  assign timeout = run_ok && (cur.count == wdr_pkg::COUNT_ZERO);

  always_comb begin
    rd_mux = wdr_pkg::WORD_ZERO;
    case (cur.dph_addr)
      wdr_pkg::OFS_LOAD:    rd_mux = cur.load;
      wdr_pkg::OFS_VALUE:   rd_mux = cur.count;
      wdr_pkg::OFS_CTL: begin
        rd_mux[wdr_pkg::BIT_TIMEOUT_IRQ_ENABLE] = cur.timeout_irq_enable;
        rd_mux[wdr_pkg::BIT_SYSTEM_RESET_ENABLE] = cur.system_reset_enable;
      end
      wdr_pkg::OFS_RIS:     rd_mux[wdr_pkg::BIT_STATUS] = cur.ris;
      wdr_pkg::OFS_MIS:     rd_mux[wdr_pkg::BIT_STATUS] = cur.ris && cur.timeout_irq_enable;
      wdr_pkg::OFS_CLKGATE: rd_mux[wdr_pkg::BIT_CLKEN]  = cur.clk_gate;
      wdr_pkg::OFS_TEST:    rd_mux[wdr_pkg::BIT_STALL]  = cur.stall_en;
      wdr_pkg::OFS_LOCK:    rd_mux[wdr_pkg::BIT_STATUS] = cur.locked;
      default:              rd_mux = wdr_pkg::WORD_ZERO;
    endcase
  end

  always_comb begin
    next_cur = cur;

    // Bus phase tracking; reads take one wait state so a write just before is visible
    case (cur.phase)
      wdr_pkg::WDR_PH_RWAIT: begin
        next_cur.phase = wdr_pkg::WDR_PH_RDONE;
        next_cur.rdata = rd_mux;
      end
      wdr_pkg::WDR_PH_IDLE,
      wdr_pkg::WDR_PH_WRITE,
      wdr_pkg::WDR_PH_RDONE: begin
        if (accept) begin
          next_cur.phase    = hwrite_in ? wdr_pkg::WDR_PH_WRITE : wdr_pkg::WDR_PH_RWAIT;
          next_cur.dph_addr = haddr_in[11:0];
        end else begin
          next_cur.phase = wdr_pkg::WDR_PH_IDLE;
        end
      end
      default: begin
        next_cur.phase = wdr_pkg::WDR_PH_IDLE;
      end
    endcase

    // Down counting and time-outs
    if (run_ok) begin
      if (timeout) begin
        next_cur.ris   = 1'b1;
        next_cur.count = cur.load;
        if (cur.ris && cur.system_reset_enable) begin
          next_cur.rst_req = 1'b1;
        end
      end else begin
        next_cur.count = cur.count - wdr_pkg::COUNT_STEP;
      end
    end

    // Clear: a time-out in the same cycle wins, so the event is not lost
    if (wr_icr) begin
      next_cur.count = cur.load;
      next_cur.ris   = timeout;
    end

    // New interval takes effect at once; pending flag is never cleared here
    if (wr_load) begin
      next_cur.load  = hwdata_in;
      next_cur.count = hwdata_in;
      if ((hwdata_in == wdr_pkg::COUNT_ZERO) && cur.timeout_irq_enable) begin
        next_cur.ris = 1'b1;
      end
    end

    // Control is write-once: after enable only hardware reset reopens it
    if (wr_ctl && !cur.timeout_irq_enable) begin
      next_cur.timeout_irq_enable = hwdata_in[wdr_pkg::BIT_TIMEOUT_IRQ_ENABLE];
      next_cur.system_reset_enable = hwdata_in[wdr_pkg::BIT_SYSTEM_RESET_ENABLE];
      if (hwdata_in[wdr_pkg::BIT_TIMEOUT_IRQ_ENABLE]) begin
        next_cur.count = cur.load;
      end
    end

    if (wr && !cur.locked && (cur.dph_addr == wdr_pkg::OFS_TEST)) begin
      next_cur.stall_en = hwdata_in[wdr_pkg::BIT_STALL];
    end
    if (wr && !cur.locked && (cur.dph_addr == wdr_pkg::OFS_CLKGATE)) begin
      next_cur.clk_gate = hwdata_in[wdr_pkg::BIT_CLKEN];
    end

    // Lock register stays writable while locked, otherwise it could never unlock
    if (wr && (cur.dph_addr == wdr_pkg::OFS_LOCK)) begin
      next_cur.locked = (hwdata_in != wdr_pkg::UNLOCK_KEY);
    end
  end

  // Reset request is sticky; only rst_in clears it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cur <= wdr_pkg::STATE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign hreadyout_out  = (cur.phase != wdr_pkg::WDR_PH_RWAIT);
  assign hresp_out      = 1'b0;
  assign hrdata_out     = cur.rdata;
  assign irq_out        = cur.ris && cur.timeout_irq_enable;
  assign wdog_reset_out = cur.rst_req;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_count_dec;
    (run_ok && !timeout && !wr_load && !wr_icr)
      |=> (cur.count == $past(cur.count) - wdr_pkg::COUNT_STEP);
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("counter did not step down");

  property p_first_timeout;
    timeout |=> cur.ris && irq_out;
  endproperty
  a_first_timeout: assert property (p_first_timeout) else $error("no time-out flag");

  property p_reload;
    (timeout && !wr_load) |=> (cur.count == $past(cur.load));
  endproperty
  a_reload: assert property (p_reload) else $error("no reload after time-out");

  property p_second_reset;
    (timeout && cur.ris && cur.system_reset_enable) |=> wdog_reset_out;
  endproperty
  a_second_reset: assert property (p_second_reset) else $error("no reset at second time-out");

  property p_clear_no_reset;
    (wr_icr && !timeout && !cur.rst_req) |=> !cur.ris ##0 !wdog_reset_out;
  endproperty
  a_clear_no_reset: assert property (p_clear_no_reset) else $error("clear failed");

  property p_load_write;
    wr_load |=> (cur.count == $past(hwdata_in)) && (cur.load == $past(hwdata_in));
  endproperty
  a_load_write: assert property (p_load_write) else $error("load write not applied");

  property p_load_keeps_irq;
    (wr_load && cur.ris) |=> cur.ris;
  endproperty
  a_load_keeps_irq: assert property (p_load_keeps_irq) else $error("load cleared irq");

  property p_enable_preload;
    (wr_ctl && !cur.timeout_irq_enable && hwdata_in[wdr_pkg::BIT_TIMEOUT_IRQ_ENABLE])
      |=> cur.timeout_irq_enable && (cur.count == $past(cur.load));
  endproperty
  a_enable_preload: assert property (p_enable_preload) else $error("no preload on enable");

  property p_locked_load;
    (wr && cur.locked && cur.dph_addr == wdr_pkg::OFS_LOAD) |=> $stable(cur.load);
  endproperty
  a_locked_load: assert property (p_locked_load) else $error("locked load changed");

  property p_stall;
    (cur.timeout_irq_enable && cur.stall_en && debug_halt_in && !wr_load && !wr_icr && !wr_ctl)
      |=> $stable(cur.count);
  endproperty
  a_stall: assert property (p_stall) else $error("count moved while stalled");

  property p_no_reset_disabled;
    !cur.system_reset_enable |-> !wdog_reset_out;
  endproperty
  a_no_reset_disabled: assert property (p_no_reset_disabled) else $error("reset while off");

  property p_zero_load;
    (wr_load && cur.timeout_irq_enable && hwdata_in == wdr_pkg::COUNT_ZERO) |=> irq_out;
  endproperty
  a_zero_load: assert property (p_zero_load) else $error("zero load gave no irq");

  property p_ctl_frozen;
    (wr && cur.timeout_irq_enable && cur.dph_addr == wdr_pkg::OFS_CTL) |=> cur.timeout_irq_enable && $stable(cur.system_reset_enable);
  endproperty
  a_ctl_frozen: assert property (p_ctl_frozen) else $error("control changed after enable");

  property p_reset_held;
    wdog_reset_out |=> wdog_reset_out [*4];
  endproperty
  a_reset_held: assert property (p_reset_held) else $error("reset request dropped");

  // Enable doubles as run control, so a disabled counter must not move
  property p_idle_hold;
    (!cur.timeout_irq_enable && !wr_load && !wr_icr && !wr_ctl) |=> $stable(cur.count);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved while off");

  property p_gate_hold;
    (!cur.clk_gate && !wr_load && !wr_icr && !wr_ctl) |=> $stable(cur.count);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count moved while gated");

  property p_gate_write;
    (wr && !cur.locked && cur.dph_addr == wdr_pkg::OFS_CLKGATE
      && !hwdata_in[wdr_pkg::BIT_CLKEN]) |=> !cur.clk_gate;
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("clock gate not cleared");

  property p_stall_write;
    (wr && !cur.locked && cur.dph_addr == wdr_pkg::OFS_TEST
      && hwdata_in[wdr_pkg::BIT_STALL]) |=> cur.stall_en;
  endproperty
  a_stall_write: assert property (p_stall_write) else $error("stall enable not set");

  property p_stall_resume;
    (cur.stall_en && $fell(debug_halt_in) && run_ok && !timeout && !wr_load && !wr_icr)
      |=> (cur.count == $past(cur.count) - wdr_pkg::COUNT_STEP);
  endproperty
  a_stall_resume: assert property (p_stall_resume) else $error("stall resume wrong");

  // Status reads return the flag as it stood during the wait cycle
  property p_raw_read;
    (cur.phase == wdr_pkg::WDR_PH_RWAIT && cur.dph_addr == wdr_pkg::OFS_RIS)
      |=> (hrdata_out[wdr_pkg::BIT_STATUS] == $past(cur.ris));
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw status misread");

  property p_masked_read;
    (cur.phase == wdr_pkg::WDR_PH_RWAIT && cur.dph_addr == wdr_pkg::OFS_MIS)
      |=> (hrdata_out[wdr_pkg::BIT_STATUS] == $past(irq_out));
  endproperty
  a_masked_read: assert property (p_masked_read) else $error("masked status misread");

  property p_clear_reload;
    wr_icr |=> (cur.count == $past(cur.load));
  endproperty
  a_clear_reload: assert property (p_clear_reload) else $error("clear did not reload");

  // A locked block refuses the clear too, so hung software still ends in reset
  property p_locked_clear;
    (wr && cur.locked && cur.dph_addr == wdr_pkg::OFS_ICR && !timeout)
      |=> $stable(cur.ris);
  endproperty
  a_locked_clear: assert property (p_locked_clear) else $error("locked clear applied");

  property p_locked_ctl;
    (wr && cur.locked && cur.dph_addr == wdr_pkg::OFS_CTL)
      |=> $stable(cur.timeout_irq_enable) && $stable(cur.system_reset_enable);
  endproperty
  a_locked_ctl: assert property (p_locked_ctl) else $error("locked control changed");

  property p_lock_write;
    (wr && cur.dph_addr == wdr_pkg::OFS_LOCK)
      |=> (cur.locked == ($past(hwdata_in) != wdr_pkg::UNLOCK_KEY));
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("lock state wrong");

  // Coverage of the main scenarios
  property p_cov_first;
    timeout && !cur.ris;
  endproperty
  c_cov_first: cover property (p_cov_first);

  property p_cov_second;
    timeout && cur.ris && cur.system_reset_enable;
  endproperty
  c_cov_second: cover property (p_cov_second);

  property p_cov_clear;
    wr_icr && cur.ris;
  endproperty
  c_cov_clear: cover property (p_cov_clear);

  property p_cov_unlock;
    cur.locked && wr && cur.dph_addr == wdr_pkg::OFS_LOCK;
  endproperty
  c_cov_unlock: cover property (p_cov_unlock);

  property p_cov_stall;
    cur.timeout_irq_enable && cur.stall_en && debug_halt_in;
  endproperty
  c_cov_stall: cover property (p_cov_stall);

endmodule
